// >>> occ_top.sv
`timescale 1ns/1ns
// Summary of operation
// RL1: bits 14..12 report the running clock source read-only, 111 fast rc div-n and 110 fast rc div-16.
// RL2: the running source codes are 101 low-power rc, 100 secondary, 011 primary+pll, 010 primary, 001 fast rc+pll, 000 fast rc.
// RL3: bits 10..8 hold the software-requested source for the next switch, same codes.
// RL4: with the lock bit set and fail-safe config bit 0 high, source and pll settings cannot change.
// RL5: bit 5 reads 1 when the pll is enabled and is locked or its start-up timer expired, else 0.
// RL6: the clock-fail flag is set by the fail-safe monitor and stays until software clears it.
// RL7: writes to the control register are ignored unless the unlock sequence precedes each one.
// RL8: a direct switch between primary+pll and fast rc+pll is refused in either direction.
// RL9: the register is initialised only by power-on reset; other resets leave it alone.
// RL10: bits 11 and 4 (and 15) read as zero.
// RL11: when a switch completes the running source takes the requested value.
module occ_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  cfg_initial_source,
  input  wire logic        fail_safe_cfg_bit0,
  input  wire logic        pll_locked,
  input  wire logic        pll_timer_done,
  input  wire logic        pll_enabled,
  input  wire logic        clock_fail_detect,
  output logic      [2:0]  current_source_sel,
  output logic             secondary_osc_en,
  output logic             switch_busy
);
  occ_sw_if swi ();
  occ_switcher u_sw (
    .pclk    (pclk),
    .presetn (presetn),
    .sw      (swi.sw)
  );

  logic [2:0]           cur_src;
  logic [2:0]           req_src;
  logic                 clock_cfg_lock;
  logic                 pll_lock_stat;
  logic                 clock_fail_flag;
  logic                 lposc_en;
  logic                 sw_req;
  logic                 start_q;
  logic                 load_q;
  occ_pkg::occ_unlock_e unl;
  occ_pkg::occ_unlock_e next_unl;
  logic [2:0]           next_cur;
  logic [2:0]           next_req;
  logic                 next_lock;
  logic                 next_lposc;
  logic                 next_sw_req;
  logic                 next_start;

  wire        access      = psel & penable;
  wire        setup       = psel & ~penable;
  wire        wr          = access & pwrite;
  wire        sel_ctrl    = paddr == occ_pkg::ADDR_OSC_CTRL;
  wire        sel_unlock  = paddr == occ_pkg::ADDR_UNLOCK;
  wire        mapped      = sel_ctrl | sel_unlock;
  wire        wr_unlock   = wr & sel_unlock;
  wire        key1_seen   = wr_unlock & (pwdata == occ_pkg::UNLOCK_KEY1);
  wire        key2_seen   = wr_unlock & (pwdata == occ_pkg::UNLOCK_KEY2);
  wire        wr_ctrl_ok  = wr & sel_ctrl & (unl == occ_pkg::UNL_OPEN) & pready; // RL7
  wire        cfg_frozen  = clock_cfg_lock & fail_safe_cfg_bit0; // RL4
  wire [2:0]  w_req       = pwdata[occ_pkg::REQ_LSB +: 3];
  wire        w_lock      = pwdata[occ_pkg::LOCK_BIT];
  wire        w_fail      = pwdata[occ_pkg::FAIL_BIT];
  wire        w_lposc     = pwdata[occ_pkg::LPOSC_BIT];
  wire        w_go        = pwdata[occ_pkg::SWITCH_BIT];
  wire        pll_a       = cur_src == occ_pkg::SRC_PRI_PLL;
  wire        pll_b       = cur_src == occ_pkg::SRC_FRC_PLL;
  wire        hop_to_b    = pll_a & (w_req == occ_pkg::SRC_FRC_PLL);
  wire        hop_to_a    = pll_b & (w_req == occ_pkg::SRC_PRI_PLL);
  wire        bad_hop     = hop_to_a | hop_to_b; // RL8
  wire        req_open    = ~cfg_frozen & ~swi.busy; // RL4
  wire        w_switch    = wr_ctrl_ok & w_go & ~bad_hop & req_open;
  wire        fail_clr    = wr_ctrl_ok & ~w_fail;
  wire        next_fail   = clock_fail_detect | (clock_fail_flag & ~fail_clr); // RL6
  wire        next_pll    = pll_enabled & (pll_locked | pll_timer_done); // RL5
  wire [15:0] reg_view    = {1'b0,
                             cur_src,
                             1'b0,
                             req_src,
                             clock_cfg_lock,
                             1'b0,
                             pll_lock_stat,
                             1'b0,
                             clock_fail_flag,
                             1'b0,
                             lposc_en,
                             sw_req}; // RL1 RL2 RL10
  wire [31:0] rd_mux      = sel_ctrl ? {16'h0000, reg_view} : 32'h0000_0000;
  wire        next_ready  = setup;
  wire        next_err    = setup & ~mapped;

  // done stands one cycle, so it must not lose to a write landing in the same cycle
  assign next_cur    = load_q ? cfg_initial_source : (swi.done ? req_src : cur_src); // RL11
  assign next_req    = load_q ? cfg_initial_source : ((wr_ctrl_ok & req_open) ? w_req : req_src); // RL3
  assign next_lock   = clock_cfg_lock | (wr_ctrl_ok & w_lock);
  assign next_lposc  = wr_ctrl_ok ? w_lposc : lposc_en;
  assign next_sw_req = w_switch | (sw_req & ~swi.done);
  assign next_start  = w_switch;

  // any bus access other than key two right after key one closes the unlock window, so one write per sequence
  always_comb begin
    next_unl = unl;
    if (key1_seen) begin
      next_unl = occ_pkg::UNL_KEY1;
    end else if (key2_seen && unl == occ_pkg::UNL_KEY1) begin
      next_unl = occ_pkg::UNL_OPEN;
    end else if (access) begin
      case (unl)
        occ_pkg::UNL_IDLE: next_unl = occ_pkg::UNL_IDLE;
        occ_pkg::UNL_KEY1: next_unl = occ_pkg::UNL_IDLE;
        occ_pkg::UNL_OPEN: next_unl = occ_pkg::UNL_IDLE;
        default:           next_unl = occ_pkg::UNL_IDLE;
      endcase
    end
  end

  assign swi.start  = start_q;
  assign swi.target = req_src;

  // presetn is the power-on reset; straps are taken one edge after its release
  always_ff @(posedge pclk or negedge presetn) begin // RL9
    if (!presetn) begin
      cur_src <= occ_pkg::SRC_FRC;
      req_src <= occ_pkg::SRC_FRC;
      load_q  <= 1'b1;
    end else begin
      cur_src <= next_cur;
      req_src <= next_req;
      load_q  <= 1'b0;
    end
  end

  // lock is write-one sticky: only power-on reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_cfg_lock <= 1'b0;
      lposc_en       <= 1'b0;
    end else begin
      clock_cfg_lock <= next_lock;
      lposc_en       <= next_lposc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      sw_req  <= next_sw_req;
      start_q <= next_start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl <= occ_pkg::UNL_IDLE;
    end else begin
      unl <= next_unl;
    end
  end

  // the monitor's detect wins over a clear written in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_lock_stat   <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      pll_lock_stat   <= next_pll;
      clock_fail_flag <= next_fail;
    end
  end

  // read data is captured from the setup-cycle address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_mux;
    end
  end

  // one wait-free access cycle: pready follows every setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_ready;
      pslverr <= next_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_source_sel <= occ_pkg::SRC_FRC;
    end else begin
      current_source_sel <= cur_src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_osc_en <= 1'b0;
    end else begin
      secondary_osc_en <= lposc_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_busy <= 1'b0;
    end else begin
      switch_busy <= sw_req;
    end
  end
endmodule : occ_top

// >>> occ_pkg.sv
package occ_pkg;
  localparam logic [11:0] ADDR_OSC_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_UNLOCK     = 12'h004;
  localparam logic [31:0] UNLOCK_KEY1     = 32'h0000_0046;
  localparam logic [31:0] UNLOCK_KEY2     = 32'h0000_0057;
  localparam int          CUR_LSB         = 12;
  localparam int          REQ_LSB         = 8;
  localparam int          LOCK_BIT        = 7;
  localparam int          PLL_LOCK_BIT    = 5;
  localparam int          FAIL_BIT        = 3;
  localparam int          LPOSC_BIT       = 1;
  localparam int          SWITCH_BIT      = 0;
  localparam logic [2:0]  SRC_FRC         = 3'h0;
  localparam logic [2:0]  SRC_FRC_PLL     = 3'h1;
  localparam logic [2:0]  SRC_PRI         = 3'h2;
  localparam logic [2:0]  SRC_PRI_PLL     = 3'h3;
  localparam logic [2:0]  SRC_SOSC        = 3'h4;
  localparam logic [2:0]  SRC_LOW_POWER_RC        = 3'h5;
  localparam logic [2:0]  SRC_FRC_DIV16   = 3'h6;
  localparam logic [2:0]  SRC_FRC_DIV_N   = 3'h7;
  localparam int          SWITCH_TIME_NS  = 100;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam logic [7:0]  SWITCH_CYCLES   = 8'((SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} occ_unlock_e;
endpackage : occ_pkg

// >>> occ_sw_if.sv
`timescale 1ns/1ns
interface occ_sw_if;
  logic       start;
  logic [2:0] target;
  logic       busy;
  logic       done;
  modport ctrl (output start, output target, input busy, input done);
  modport sw   (input start, input target, output busy, output done);
endinterface : occ_sw_if

// >>> occ_switcher.sv
`timescale 1ns/1ns
module occ_switcher (
  input  wire logic pclk,
  input  wire logic presetn,
  occ_sw_if.sw      sw
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       busy;
  logic       done;

  // a fixed settle time stands in for the oscillator start and glitchless handover
  assign next_count = sw.start ? occ_pkg::SWITCH_CYCLES : (count != 8'h00 ? count - 8'h01 : 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= sw.start | (count > 8'h01);
      done  <= busy & (count == 8'h01);
    end
  end

  assign sw.busy = busy;
  assign sw.done = done;
endmodule : occ_switcher

// >>> occ_asserts.sv
`timescale 1ns/1ns
module occ_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [2:0]  cfg_initial_source,
  input wire logic        fail_safe_cfg_bit0,
  input wire logic        clock_fail_detect,
  input wire logic [2:0]  current_source_sel,
  input wire logic        switch_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       key1, open, lk, sf;
  logic [2:0] req;
  wire done = pready && pwrite;
  wire okw  = done && paddr == 12'h000 && open;
  wire rdc  = pready && !pwrite && paddr == 12'h000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {key1, open, lk, req} <= 6'h00;
    end else if (pready) begin
      key1 <= done && paddr == 12'h004 && pwdata == occ_pkg::UNLOCK_KEY1;
      open <= key1 && done && paddr == 12'h004 && pwdata == occ_pkg::UNLOCK_KEY2;
      lk   <= lk | (okw & pwdata[7]);
      req  <= (okw && !(lk && fail_safe_cfg_bit0)) ? pwdata[10:8] : req;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sf <= 1'b0;
    end else begin
      sf <= clock_fail_detect | (sf & ~(okw & ~pwdata[3]));
    end
  end
  sequence s_start; $rose(switch_busy); endsequence
  sequence s_finish; $fell(switch_busy); endsequence
  a_zero_bits: assert property (rdc |-> prdata[31:15] == 17'h0 && !prdata[11] && !prdata[4])
    else $error("reserved bits not zero");
  a_unlock_first: assert property (s_start |-> $past(okw, 2))
    else $error("switch without unlocked write");
  a_no_pll_hop: assert property (s_start |-> !({current_source_sel, req} inside {6'o31, 6'o13}))
    else $error("direct pll hop started");
  a_frozen_cfg: assert property (s_start |-> !$past(lk && fail_safe_cfg_bit0, 2))
    else $error("switch while frozen");
  a_switch_lands: assert property (s_finish |-> current_source_sel == req)
    else $error("source differs from request");
  a_fail_held: assert property (rdc |-> prdata[3] == $past(sf))
    else $error("fail flag not set");
  a_reset_load: assert property ($rose(presetn) |-> ##2 current_source_sel == cfg_initial_source)
    else $error("strap not loaded");
  a_cur_readback: assert property ($stable(current_source_sel)[*3] ##0 rdc |-> prdata[14:12] == current_source_sel)
    else $error("current field differs");
endmodule : occ_asserts
bind occ_top occ_asserts u_occ_asserts (.*);

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  strap, cur, t, e, v;
  logic        fs0, plk, ptd, pen, cfd, busy, sosc;
  int          num_errors, samples_checked, n;
  occ_top u_occ_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_initial_source(strap), .fail_safe_cfg_bit0(fs0), .pll_locked(plk), .pll_timer_done(ptd),
    .pll_enabled(pen), .clock_fail_detect(cfd), .current_source_sel(cur), .secondary_osc_en(sosc),
    .switch_busy(busy));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // one idle edge first so psel is never assigned twice in a time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; pready !== 1'b1; n++) begin
      if (n > 20) begin num_errors++; report_and_stop(); end
      @(posedge pclk);
    end
    {r, se} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : xfer
  task automatic ctl(input logic [15:0] d);
    xfer(1'b1, occ_pkg::ADDR_UNLOCK, occ_pkg::UNLOCK_KEY1);
    xfer(1'b1, occ_pkg::ADDR_UNLOCK, occ_pkg::UNLOCK_KEY2);
    xfer(1'b1, occ_pkg::ADDR_OSC_CTRL, {16'h0, d});
    repeat (3) @(posedge pclk);
    for (n = 0; busy !== 1'b0; n++) begin
      if (n > 40) begin num_errors++; report_and_stop(); end
      @(posedge pclk);
    end
    xfer(1'b0, occ_pkg::ADDR_OSC_CTRL, 32'h0);
  endtask : ctl
  function automatic logic [31:0] ev(input logic [2:0] c, q, input logic lk, pl, cf);
    return {17'h0, c, 1'b0, q, lk, 1'b0, pl, 1'b0, cf, 3'h0};
  endfunction : ev
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, strap, fs0, plk, ptd, pen, cfd} = '0;
    {num_errors, samples_checked, e} = '0;
    n = $urandom(32'h2a653f98);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h000, 32'h0);
    chk(r, ev(3'h0, 3'h0, 0, 0, 0), "reset value");
    xfer(1'b1, occ_pkg::ADDR_UNLOCK, occ_pkg::UNLOCK_KEY1);
    xfer(1'b1, occ_pkg::ADDR_UNLOCK, occ_pkg::UNLOCK_KEY2);
    xfer(1'b0, occ_pkg::ADDR_OSC_CTRL, 32'h0);
    xfer(1'b1, occ_pkg::ADDR_OSC_CTRL, 32'h0501);
    xfer(1'b0, occ_pkg::ADDR_OSC_CTRL, 32'h0);
    chk(r, ev(3'h0, 3'h0, 0, 0, 0), "stale unlock");
    for (int i = 0; i < 16; i++) begin
      t = 3'($urandom);
      v = 3'($urandom);
      if ({e, t} inside {6'o31, 6'o13}) t = occ_pkg::SRC_FRC;
      {pen, plk, ptd} <= v[2] ? v : 3'h0;
      ctl({5'h0, t, 8'h01});
      e = t;
      chk(r, ev(t, t, 0, v[2] & |v[1:0], 0), "switch");
    end
    ctl(16'h0001);
    ctl(16'h0301);
    ctl(16'h0101);
    chk({29'h0, cur}, 32'h3, "pll hop");
    cfd <= 1'b1;
    @(posedge pclk) cfd <= 1'b0;
    xfer(1'b0, 12'h000, 32'h0);
    chk({31'h0, r[3]}, 32'h1, "fail set");
    ctl(16'h0302);
    chk(r, ev(3'h3, 3'h3, 0, v[2] & |v[1:0], 0) | 32'h0000_0002, "fail clear");
    chk({29'h0, r[10:8]}, 32'h3, "requested field");
    chk({31'h0, sosc}, 32'h1, "secondary enable");
    fs0 <= 1'b1;
    ctl(16'h0380);
    ctl(16'h0001);
    chk(r, ev(3'h3, 3'h3, 1, v[2] & |v[1:0], 0), "frozen");
    xfer(1'b0, 12'h008, 32'h0);
    chk({r[31:1], se}, 32'h1, "unmapped");
    strap <= 3'h5;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h000, 32'h0);
    chk(r, ev(3'h5, 3'h5, 0, v[2] & |v[1:0], 0), "second reset");
    report_and_stop();
  end
endmodule : tb_top
